// File: hw/osh_defs.svh
`ifndef OSH_DEFS_SVH
`define OSH_DEFS_SVH
// =====================================================================
// Timing
`define OSH_CLK_HZ 20000000
`define OSH_TICK_S 1
// =====================================================================
// Register byte offsets
`define OSH_OFF_CFG 12'h000
`define OSH_OFF_STATE 12'h004
`define OSH_OFF_IRQ_STAT 12'h008
`define OSH_OFF_IRQ_CLR 12'h00C
`define OSH_OFF_IRQ_EN 12'h010
`define OSH_OFF_FAULT 12'h014
// =====================================================================
// Configuration fields, each 8 bits of seconds
`define OSH_CFG_PRE_LSB 0
`define OSH_CFG_POST_LSB 8
`define OSH_CFG_WD_LSB 16
`define OSH_CFG_RST 32'h00000202
// =====================================================================
// State register fields
`define OSH_ST_OUT 0
`define OSH_ST_GAS 1
`define OSH_ST_SUP 2
`define OSH_ST_ACT 3
`define OSH_ST_FLT 4
`define OSH_ST_MOD 5
`define OSH_ST_ILK 6
`define OSH_ST_PROG_LSB 8
`define OSH_ST_REM_LSB 12
`define OSH_ST_DISP_LSB 16
`define OSH_ST_CTRL_LSB 20
`define OSH_ST_CUR_LSB 24
// =====================================================================
// Interrupt bits
`define OSH_IRQ_W 4
`define OSH_IRQ_HB 0
`define OSH_IRQ_ILK 1
`define OSH_IRQ_REFUSE 2
`define OSH_IRQ_RUN 3
// =====================================================================
// Fault code and screens
`define OSH_FAULT_HB 8'h17
`define OSH_SCREENS 3'h7
`define OSH_MAIN_SCREEN 3'h0
`endif

// File: hw/osh_pkg.sv
package osh_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_PREFLOW, ST_RUN, ST_POSTFLOW} osh_state_t;
  typedef enum logic [1:0] {RM_NONE, RM_ENABLE_DB37, RM_ALL_DB37, RM_SERIAL} osh_remote_t;
endpackage

// File: hw/osh_output_sequencer.sv
`include "osh_defs.svh"

// Contract
// - gas first, supplies after pre-flow time
// - gas kept on for post-flow time
// - zero watchdog time disables the watchdog
// - watchdog runs only in active serial mode
// - activate command in serial mode starts watchdog
// - each valid command restarts the timeout
// - timeout latches fault 23, drops output
// - deactivate clears fault, activate resumes
// - open interlock keeps power outputs off
// - output on blocks remote and display changes
// - item-select cycles only program setpoint fields
// - held select plus ccw reaches other settings
// - four stored programs of setpoints
// - altered setpoint shows modified indicator
// - load/save on program field saves slot
// - load/save elsewhere reloads and clears modified
// - output enable only on main screen
// - activate only honoured in serial remote mode
module osh_output_sequencer
  import osh_pkg::*;
#(
  parameter int NSP = 8,
  parameter int SPW = 16,
  parameter int NPROG = 4,
  parameter int TICK_CYCLES = `OSH_CLK_HZ * `OSH_TICK_S
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic btn_item_select,
  input wire logic item_held,
  input wire logic knob_cw,
  input wire logic knob_ccw,
  input wire logic btn_load_save,
  input wire logic btn_enable,
  input wire logic interlock_closed,
  input wire logic ser_cmd_valid,
  input wire logic ser_cmd_activate,
  input wire logic ser_cmd_deactivate,
  input wire logic ser_cmd_enable,
  input wire logic ser_cmd_standby,
  output logic gas_on,
  output logic supplies_on,
  output logic output_on,
  output logic active_serial_remote,
  output logic heartbeat_timeout_fault,
  output logic setpoint_modified,
  output logic [$clog2(NPROG)-1:0] program_num,
  output logic [NSP*SPW-1:0] setpoints,
  output logic irq
);
  localparam int CW = $clog2(NSP + 4);
  localparam int PW = $clog2(NPROG);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] CUR_CTRL = CW'(NSP + 1);
  localparam logic [CW-1:0] CUR_REM = CW'(NSP + 2);
  localparam logic [CW-1:0] CUR_DISP = CW'(NSP + 3);

  function automatic logic tick_hit(input logic [TW-1:0] c);
    return c == TW'(TICK_CYCLES - 1);
  endfunction

  function automatic logic [7:0] sec_inc(input logic [7:0] s);
    return (s == 8'hFF) ? s : s + 8'h01;
  endfunction

  logic [31:0] cfg_q;
  logic [`OSH_IRQ_W-1:0] irq_stat_q, irq_en_q, irq_stat_d, irq_ev;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  osh_state_t state_q, state_d;
  logic [TW-1:0] flow_pre_q, wd_pre_q;
  logic [7:0] flow_sec_q, wd_sec_q;
  logic gas_on_q, supplies_on_q, output_on_q, irq_q;
  logic active_q, fault_q, modified_q;
  logic [CW-1:0] cursor_q;
  logic [PW-1:0] prog_q;
  osh_remote_t remote_q;
  logic [2:0] display_q;
  logic [1:0] ctrl_q;
  logic [SPW-1:0] sp_q [NSP];
  logic [SPW-1:0] mem_q [NPROG][NSP];

  logic [7:0] pre_time, post_time, wd_time;
  assign pre_time = cfg_q[`OSH_CFG_PRE_LSB +: 8];
  assign post_time = cfg_q[`OSH_CFG_POST_LSB +: 8];
  assign wd_time = cfg_q[`OSH_CFG_WD_LSB +: 8];

  // ===================================================================
  // APB slave: one wait-free access phase, registered answer
  logic setup, done, addr_ok;
  logic [31:0] rd_mux, state_word;
  assign setup = psel & ~penable;
  assign done = psel & penable & pready_q;
  assign addr_ok = paddr == `OSH_OFF_CFG || paddr == `OSH_OFF_STATE ||
                   paddr == `OSH_OFF_IRQ_STAT || paddr == `OSH_OFF_IRQ_CLR ||
                   paddr == `OSH_OFF_IRQ_EN || paddr == `OSH_OFF_FAULT;

  always_comb begin
    state_word = 32'h00000000;
    state_word[`OSH_ST_OUT] = output_on_q;
    state_word[`OSH_ST_GAS] = gas_on_q;
    state_word[`OSH_ST_SUP] = supplies_on_q;
    state_word[`OSH_ST_ACT] = active_q;
    state_word[`OSH_ST_FLT] = fault_q;
    state_word[`OSH_ST_MOD] = modified_q;
    state_word[`OSH_ST_ILK] = interlock_closed;
    state_word[`OSH_ST_PROG_LSB +: PW] = prog_q;
    state_word[`OSH_ST_REM_LSB +: 2] = remote_q;
    state_word[`OSH_ST_DISP_LSB +: 3] = display_q;
    state_word[`OSH_ST_CTRL_LSB +: 2] = ctrl_q;
    state_word[`OSH_ST_CUR_LSB +: CW] = cursor_q;
  end

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (paddr)
      `OSH_OFF_CFG: rd_mux = cfg_q;
      `OSH_OFF_STATE: rd_mux = state_word;
      `OSH_OFF_IRQ_STAT: rd_mux[`OSH_IRQ_W-1:0] = irq_stat_q;
      `OSH_OFF_IRQ_EN: rd_mux[`OSH_IRQ_W-1:0] = irq_en_q;
      `OSH_OFF_FAULT: rd_mux[7:0] = fault_q ? `OSH_FAULT_HB : 8'h00;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~addr_ok;
      prdata_q <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= `OSH_CFG_RST;
      irq_en_q <= '0;
    end else if (done & pwrite) begin
      if (paddr == `OSH_OFF_CFG) cfg_q <= {8'h00, pwdata[23:0]};
      if (paddr == `OSH_OFF_IRQ_EN) irq_en_q <= pwdata[`OSH_IRQ_W-1:0];
    end
  end

  // ===================================================================
  // Interrupts: sticky status, set wins over clear
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (done & pwrite & (paddr == `OSH_OFF_IRQ_CLR))
      irq_stat_d = irq_stat_d & ~pwdata[`OSH_IRQ_W-1:0];
    irq_stat_d = irq_stat_d | irq_ev;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_d & irq_en_q);
    end
  end

  // ===================================================================
  // Output sequencer
  logic panel_ok, en_req, stby_req, start_ok, drop, refuse_ev, pre_done, timeout;
  assign panel_ok = ~active_q;
  assign en_req = active_q ? (ser_cmd_valid & ser_cmd_enable)
                           : (btn_enable & (state_q == ST_IDLE || state_q == ST_POSTFLOW));
  assign stby_req = active_q ? (ser_cmd_valid & ser_cmd_standby)
                             : (btn_enable & (state_q == ST_PREFLOW || state_q == ST_RUN));
  assign start_ok = (display_q == `OSH_MAIN_SCREEN) & interlock_closed & ~fault_q;
  assign drop = stby_req | ~interlock_closed | fault_q;
  assign pre_done = flow_sec_q >= pre_time;
  assign refuse_ev = en_req & ~start_ok & (state_q == ST_IDLE || state_q == ST_POSTFLOW);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (en_req & start_ok) state_d = ST_PREFLOW;
      ST_PREFLOW: begin
        if (drop) state_d = ST_POSTFLOW;
        else if (pre_done) state_d = ST_RUN;
      end
      ST_RUN: if (drop) state_d = ST_POSTFLOW;
      ST_POSTFLOW: begin
        if (en_req & start_ok) state_d = ST_PREFLOW;
        else if (flow_sec_q >= post_time) state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      gas_on_q <= 1'b0;
      supplies_on_q <= 1'b0;
      output_on_q <= 1'b0;
    end else begin
      state_q <= state_d;
      gas_on_q <= state_d != ST_IDLE;
      supplies_on_q <= (state_d == ST_RUN) & interlock_closed;
      output_on_q <= (state_d == ST_PREFLOW) || (state_d == ST_RUN);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flow_pre_q <= '0;
      flow_sec_q <= 8'h00;
    end else if (state_d != state_q) begin
      flow_pre_q <= '0;
      flow_sec_q <= 8'h00;
    end else begin
      flow_pre_q <= tick_hit(flow_pre_q) ? '0 : flow_pre_q + TW'(1);
      if (tick_hit(flow_pre_q)) flow_sec_q <= sec_inc(flow_sec_q);
    end
  end

  // ===================================================================
  // Serial remote and heartbeat watchdog
  logic wd_run, act_cmd, deact_cmd;
  assign act_cmd = ser_cmd_valid & ser_cmd_activate & (remote_q == RM_SERIAL);
  assign deact_cmd = ser_cmd_valid & ser_cmd_deactivate;
  assign wd_run = active_q & (wd_time != 8'h00) & ~fault_q;
  assign timeout = wd_run & (wd_sec_q >= wd_time);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_q <= 1'b0;
    end else if (deact_cmd) begin
      active_q <= 1'b0;
    end else if (act_cmd) begin
      active_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fault_q <= 1'b0;
    end else if (timeout) begin
      fault_q <= 1'b1;
    end else if (deact_cmd) begin
      fault_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wd_pre_q <= '0;
      wd_sec_q <= 8'h00;
    end else if (ser_cmd_valid || !wd_run) begin
      wd_pre_q <= '0;
      wd_sec_q <= 8'h00;
    end else begin
      wd_pre_q <= tick_hit(wd_pre_q) ? '0 : wd_pre_q + TW'(1);
      if (tick_hit(wd_pre_q)) wd_sec_q <= sec_inc(wd_sec_q);
    end
  end

  assign irq_ev = {(state_q == ST_PREFLOW) && (state_d == ST_RUN), refuse_ev,
                   output_on_q & ~interlock_closed, timeout};

  // ===================================================================
  // Front panel cursor and settings
  logic adj, up, sel_adv, sel_back, ls;
  assign adj = panel_ok & (knob_cw ^ knob_ccw) & ~item_held;
  assign up = knob_cw;
  assign sel_adv = panel_ok & btn_item_select;
  assign sel_back = panel_ok & knob_ccw & item_held & ~btn_item_select;
  assign ls = panel_ok & btn_load_save;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cursor_q <= '0;
    end else if (sel_adv) begin
      cursor_q <= (cursor_q >= CW'(NSP)) ? '0 : cursor_q + CW'(1);
    end else if (sel_back) begin
      if (cursor_q == '0) cursor_q <= output_on_q ? CUR_CTRL : CUR_DISP;
      else if (output_on_q && cursor_q == CUR_DISP) cursor_q <= CUR_CTRL;
      else cursor_q <= cursor_q - CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= 2'h0;
      remote_q <= RM_NONE;
      display_q <= `OSH_MAIN_SCREEN;
    end else if (adj) begin
      if (cursor_q == CUR_CTRL) ctrl_q <= up ? ctrl_q + 2'h1 : ctrl_q - 2'h1;
      if (cursor_q == CUR_REM && !output_on_q)
        remote_q <= osh_remote_t'(up ? remote_q + 2'h1 : remote_q - 2'h1);
      if (cursor_q == CUR_DISP && !output_on_q) begin
        if (up) display_q <= (display_q == `OSH_SCREENS - 3'h1) ? 3'h0 : display_q + 3'h1;
        else display_q <= (display_q == 3'h0) ? `OSH_SCREENS - 3'h1 : display_q - 3'h1;
      end
    end
  end

  // ===================================================================
  // Program store
  logic prog_chg, sp_adj;
  logic [PW-1:0] prog_next;
  assign prog_chg = adj & (cursor_q == '0);
  assign sp_adj = adj & (cursor_q != '0) & (cursor_q <= CW'(NSP));
  always_comb begin
    prog_next = prog_q;
    if (up) prog_next = (prog_q == PW'(NPROG - 1)) ? '0 : prog_q + PW'(1);
    else prog_next = (prog_q == '0) ? PW'(NPROG - 1) : prog_q - PW'(1);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prog_q <= '0;
      for (int p = 0; p < NPROG; p++)
        for (int i = 0; i < NSP; i++) mem_q[p][i] <= '0;
      for (int i = 0; i < NSP; i++) sp_q[i] <= '0;
    end else begin
      if (prog_chg) begin
        prog_q <= prog_next;
        for (int i = 0; i < NSP; i++) sp_q[i] <= mem_q[prog_next][i];
      end
      if (ls && cursor_q == '0)
        for (int i = 0; i < NSP; i++) mem_q[prog_q][i] <= sp_q[i];
      if (ls && cursor_q != '0)
        for (int i = 0; i < NSP; i++) sp_q[i] <= mem_q[prog_q][i];
      for (int i = 0; i < NSP; i++)
        if (sp_adj && cursor_q == CW'(i + 1)) begin
          if (up && sp_q[i] != '1) sp_q[i] <= sp_q[i] + SPW'(1);
          else if (!up && sp_q[i] != '0) sp_q[i] <= sp_q[i] - SPW'(1);
        end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) modified_q <= 1'b0;
    else if (sp_adj) modified_q <= 1'b1;
    else if (ls || prog_chg) modified_q <= 1'b0;
  end

  // ===================================================================
  // Outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign gas_on = gas_on_q;
  assign supplies_on = supplies_on_q;
  assign output_on = output_on_q;
  assign active_serial_remote = active_q;
  assign heartbeat_timeout_fault = fault_q;
  assign setpoint_modified = modified_q;
  assign program_num = prog_q;
  assign irq = irq_q;
  for (genvar g = 0; g < NSP; g++) begin : g_sp
    assign setpoints[g*SPW +: SPW] = sp_q[g];
  end

  // ===================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_sup_after_gas;
    supplies_on_q |-> gas_on_q && state_q == ST_RUN && $past(state_q) != ST_IDLE;
  endproperty
  a_sup_after_gas: assert property (p_sup_after_gas) else $error("supplies without pre-flow");

  property p_postflow_gas;
    (state_q == ST_POSTFLOW && flow_sec_q < post_time && !en_req) |=> gas_on_q;
  endproperty
  a_postflow_gas: assert property (p_postflow_gas) else $error("gas cut before post-flow");

  property p_wd_zero;
    wd_time == 8'h00 |-> !timeout;
  endproperty
  a_wd_zero: assert property (p_wd_zero) else $error("timeout with watchdog disabled");

  property p_wd_active;
    timeout |-> $past(active_q) && active_q;
  endproperty
  a_wd_active: assert property (p_wd_active) else $error("timeout outside active serial");

  property p_act;
    act_cmd && !deact_cmd |=> active_q && wd_sec_q == 8'h00;
  endproperty
  a_act: assert property (p_act) else $error("activate not honoured");

  property p_restart;
    ser_cmd_valid |=> wd_sec_q == 8'h00 && wd_pre_q == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("command did not restart watchdog");

  sequence s_fault_latched;
    fault_q && !output_on_q;
  endsequence
  property p_timeout;
    timeout && !deact_cmd |=> fault_q ##1 s_fault_latched;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not fault and drop");

  property p_recover;
    deact_cmd && !timeout |=> !fault_q && !active_q;
  endproperty
  a_recover: assert property (p_recover) else $error("deactivate did not clear fault");

  property p_ilk;
    !interlock_closed |=> !supplies_on_q;
  endproperty
  a_ilk: assert property (p_ilk) else $error("power on with interlock open");

  property p_lock;
    output_on_q |=> $stable(remote_q) && $stable(display_q);
  endproperty
  a_lock: assert property (p_lock) else $error("remote or display changed while on");

  property p_sel;
    sel_adv |=> cursor_q <= CW'(NSP);
  endproperty
  a_sel: assert property (p_sel) else $error("item select left setpoint fields");

  property p_mod;
    sp_adj |=> modified_q;
  endproperty
  a_mod: assert property (p_mod) else $error("modified flag not set");

  property p_reload;
    ls && !sp_adj && cursor_q != '0 |=> !modified_q && sp_q[0] == $past(mem_q[prog_q][0]);
  endproperty
  a_reload: assert property (p_reload) else $error("reload failed");

  property p_main;
    (state_q == ST_IDLE && state_d == ST_PREFLOW) |-> display_q == `OSH_MAIN_SCREEN;
  endproperty
  a_main: assert property (p_main) else $error("enabled off the main screen");

  property p_serial_only;
    $rose(active_q) |-> $past(remote_q) == RM_SERIAL && $past(ser_cmd_activate);
  endproperty
  a_serial_only: assert property (p_serial_only) else $error("active without serial mode");
endmodule

// File: bench/osh_host_model.sv
// =====================================================================
// Serial host: one received command per call, qualifiers in the same cycle
module osh_host_model (
  input wire logic clk,
  output logic ser_cmd_valid,
  output logic ser_cmd_activate,
  output logic ser_cmd_deactivate,
  output logic ser_cmd_enable,
  output logic ser_cmd_standby
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {ser_cmd_valid, ser_cmd_activate, ser_cmd_deactivate} = 3'h0;
    {ser_cmd_enable, ser_cmd_standby} = 2'h0;
  end
  // Kind: 0 leave active, 1 enter active, 2 enable, 3 standby, 4 other
  // host recovery commands
  task automatic send(input int kind);
    @(posedge clk);
    ser_cmd_valid <= 1'b1;
    ser_cmd_deactivate <= (kind == 0);
    ser_cmd_activate <= (kind == 1);
    ser_cmd_enable <= (kind == 2);
    ser_cmd_standby <= (kind == 3);
    @(posedge clk);
    {ser_cmd_valid, ser_cmd_activate, ser_cmd_deactivate} <= 3'h0;
    {ser_cmd_enable, ser_cmd_standby} <= 2'h0;
  endtask
endmodule

// File: bench/output_sequencer_heartbeat_tb.sv
module output_sequencer_heartbeat_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, ilk, held, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] pb;
  logic gas, sup, outp, act, flt, modf;
  logic [1:0] prog;
  logic [127:0] sp;
  logic v, a, d, e, s, err;
  wire [6:0] obs = {modf, irq, flt, act, outp, sup, gas};
  int n_fail = 0, tests_run = 0, n, wd;
  int sp_m[8];
  osh_output_sequencer #(.TICK_CYCLES(10)) u_osh_output_sequencer (.clk(clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .btn_item_select(pb[0]),
    .item_held(held), .knob_cw(pb[1]), .knob_ccw(pb[2]), .btn_load_save(pb[4]),
    .btn_enable(pb[3]), .interlock_closed(ilk), .ser_cmd_valid(v), .ser_cmd_activate(a),
    .ser_cmd_deactivate(d), .ser_cmd_enable(e), .ser_cmd_standby(s), .gas_on(gas),
    .supplies_on(sup), .output_on(outp), .active_serial_remote(act),
    .heartbeat_timeout_fault(flt), .setpoint_modified(modf), .program_num(prog),
    .setpoints(sp), .irq(irq));
  osh_host_model u_osh_host_model (.clk(clk), .ser_cmd_valid(v), .ser_cmd_activate(a),
    .ser_cmd_deactivate(d), .ser_cmd_enable(e), .ser_cmd_standby(s));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // =====================================================================
  // Shared tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd_);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd_;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Extra edge at the end lets the last pulse settle before any check
  task automatic press(input int b, input int cnt);
    repeat (cnt) begin
      @(posedge clk);
      pb <= 5'h01 << b;
      @(posedge clk);
      pb <= 5'h00;
    end
    @(posedge clk);
  endtask
  task automatic back(input int cnt);
    held <= 1'b1;
    press(2, cnt);
    held <= 1'b0;
  endtask
  task automatic wait_obs(input int b, input logic val, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clk);
      if (obs[b] === val) break;
    end
    if (i == lim) begin
      n_fail++;
      $display("BAD wait on output %0d expected %b", b, val);
      print_verdict();
    end
  endtask
  task automatic idle(input int cyc);
    repeat (cyc) @(posedge clk);
  endtask
  // =====================================================================
  // Main sequence
  initial begin
    {rstn, psel, penable, pwrite, held, pb, paddr, pwdata} = '0;
    ilk = 1'b1;
    n = $urandom(32'hba43201a);
    idle(2);
    rstn <= 1'b1;
    apb(0, 12'h000, 0);
    check("cfg", rd, 32'h00000202);
    apb(0, 12'h004, 0);
    check("state", rd, 32'h00000040);
    apb(0, 12'h018, 0);
    check("unmapped err", err, 1);
    apb(1, 12'h010, 32'h00000004);
    back(1);
    press(1, 1);
    press(3, 1);
    idle(3);
    check("refused on other screen", outp, 0);
    wait_obs(5, 1, 4);
    apb(1, 12'h00C, 32'h00000004);
    idle(2);
    check("irq cleared", irq, 0);
    press(2, 1);
    press(3, 1);
    wait_obs(0, 1, 4);
    check("output on", outp, 1);
    idle(12);
    check("supplies wait pre-flow", sup, 0);
    wait_obs(1, 1, 15);
    check("masked irq", irq, 0);
    apb(1, 12'h010, 32'h00000008);
    idle(2);
    check("run irq", irq, 1);
    press(1, 1);
    apb(0, 12'h004, 0);
    check("display locked", rd[18:16], 0);
    press(3, 1);
    wait_obs(1, 0, 3);
    idle(10);
    check("gas in post-flow", gas, 1);
    wait_obs(0, 0, 15);
    ilk <= 1'b0;
    press(3, 1);
    idle(3);
    check("open interlock refuses", outp, 0);
    ilk <= 1'b1;
    press(3, 1);
    wait_obs(1, 1, 30);
    ilk <= 1'b0;
    wait_obs(1, 0, 3);
    check("output dropped", outp, 0);
    ilk <= 1'b1;
    wait_obs(0, 0, 30);
    press(0, 11);
    apb(0, 12'h004, 0);
    check("cursor wrap", rd[27:24], 1);
    n = $urandom_range(5, 1);
    press(1, n);
    sp_m[0] = n;
    check("setpoint", sp[15:0], sp_m[0]);
    check("modified", modf, 1);
    press(4, 1);
    sp_m[0] = 0;
    check("reloaded", sp[15:0], sp_m[0]);
    check("modified cleared", modf, 0);
    press(1, n);
    sp_m[0] = n;
    press(0, 8);
    press(4, 1);
    check("saved", modf, 0);
    press(1, 1);
    check("program", prog, 1);
    check("empty program", sp[15:0], 0);
    press(2, 1);
    check("program 0 recall", sp[15:0], sp_m[0]);
    u_osh_host_model.send(1);
    idle(2);
    check("activate refused", act, 0);
    back(2);
    apb(0, 12'h004, 0);
    check("cursor remote", rd[27:24], 10);
    press(1, 3);
    press(0, 1);
    u_osh_host_model.send(1);
    idle(2);
    check("active", act, 1);
    idle(60);
    check("no fault with zero time", flt, 0);
    u_osh_host_model.send(0);
    wd = $urandom_range(4, 2);
    apb(1, 12'h000, 32'h00000202 | (wd << 16));
    idle(60);
    check("idle outside active", flt, 0);
    u_osh_host_model.send(1);
    u_osh_host_model.send(2);
    wait_obs(2, 1, 4);
    repeat (4) begin
      idle(wd * 10 - 8);
      u_osh_host_model.send(4);
    end
    check("command restarts count", flt, 0);
    idle(wd * 10 - 8);
    wait_obs(4, 1, 15);
    wait_obs(2, 0, 3);
    apb(0, 12'h014, 0);
    check("fault code", rd, 32'd23);
    u_osh_host_model.send(0);
    idle(2);
    check("fault cleared", flt, 0);
    check("left active", act, 0);
    u_osh_host_model.send(1);
    idle(2);
    check("active again", act, 1);
    print_verdict();
  end
endmodule
